// File: bench/umc_modem_ctrl_monitor.sv
// umc_modem_ctrl_monitor.sv: port checks for the modem control block
// assumes: bound into umc_modem_ctrl, one clock ref_clk, rst_n async low
`timescale 1ns/10ps
module umc_chk (
  input wire ref_clk,
  input wire rst_n,
  input wire master_reset,
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire cts_n,
  input wire dsr_n,
  input wire dcd_n,
  input wire ri_n,
  input wire rts_n,
  input wire dtr_n,
  input wire multi_function_pin,
  input wire intr,
  input wire tx_request,
  input wire tx_allow,
  input wire serial_out
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire mw = reg_wr && reg_addr == 3'h4;
  reg [3:0] quiet;
  // cycles since a pin moved or a register was written, saturating
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      quiet <= 4'h0;
    end else if ($changed({cts_n, dsr_n, dcd_n, ri_n}) || reg_wr) begin
      quiet <= 4'h0;
    end else if (quiet != 4'hF) begin
      quiet <= quiet + 4'h1;
    end
  end
  ////////////////////////////////////////
  chk_rst_levels: assert property (master_reset |=> rts_n && dtr_n && serial_out && multi_function_pin && !intr)
    else $error("outputs not at reset levels");
  chk_rst_clear: assert property (master_reset ##1 !master_reset && reg_rd && reg_addr == 3'h4 |=> reg_rdata == 8'h00)
    else $error("control register survived master reset");
  chk_mcr_pins: assert property (mw && reg_wdata[5:4] == 2'h0 && !master_reset ##1 !mw && !master_reset |=>
    rts_n == !$past(reg_wdata[1], 2) && dtr_n == !$past(reg_wdata[0], 2)) else $error("rts or dtr wrong");
  chk_loop_idle: assert property (mw && reg_wdata[4] ##1 !mw |=> rts_n && dtr_n)
    else $error("handshake outputs active in loop mode");
  chk_tx_gate: assert property (tx_allow |-> tx_request)
    else $error("transmit allowed without request");
  chk_sync_two: assert property ($changed(cts_n) && $past(cts_n, 2) == $past(cts_n) && $stable(tx_request)
    && !reg_wr && !$past(reg_wr) && !master_reset ##1 $stable(tx_request) |-> $stable(tx_allow))
    else $error("cts reached logic before two stages");
  chk_intr_cause: assert property ($rose(intr) |-> quiet < 4'h8)
    else $error("interrupt rose with no recent cause");
  chk_read_clear: assert property (reg_rd && reg_addr == 3'h6 && quiet > 4'h8 ##1 !reg_wr |=> !intr)
    else $error("status read left interrupt pending");
endmodule
bind umc_modem_ctrl umc_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .master_reset(master_reset),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .cts_n(cts_n), .dsr_n(dsr_n), .dcd_n(dcd_n), .ri_n(ri_n), .rts_n(rts_n), .dtr_n(dtr_n),
  .multi_function_pin(multi_function_pin), .intr(intr), .tx_request(tx_request), .tx_allow(tx_allow),
  .serial_out(serial_out));

// File: bench/umc_modem_ctrl_tb.sv
// umc_modem_ctrl_tb.sv: self-checking bench for the modem control block
// assumes: design, remote modem model and checker compiled before it
`timescale 1ns/10ps
`include "umc_regs.vh"
module umc_modem_ctrl_tb;
  reg ref_clk, rst_n, master_reset, reg_wr, reg_rd, rx_data_ready, tx_request, serial_out_in;
  reg [2:0] reg_addr;
  reg [7:0] reg_wdata, d, v;
  reg [6:0] lvl, trig;
  wire [7:0] reg_rdata;
  wire cts_n, dsr_n, dcd_n, ri_n, rts_n, dtr_n, mf, intr, rx_sample_en, tx_allow, serial_out;
  logic [7:0] exp_q[$];
  logic [3:0] p, prev, f;
  logic rd_d, last;
  int mismatches, n_compared, i, n, m;
  umc_modem_ctrl DUT (.ref_clk(ref_clk), .rst_n(rst_n), .master_reset(master_reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cts_n(cts_n),
    .dsr_n(dsr_n), .dcd_n(dcd_n), .ri_n(ri_n), .rts_n(rts_n), .dtr_n(dtr_n), .multi_function_pin(mf),
    .intr(intr), .crystal_output(), .rx_sample_en(rx_sample_en), .rx_fifo_level(lvl),
    .rx_trigger_level(trig), .rx_data_ready(rx_data_ready), .tx_request(tx_request),
    .tx_allow(tx_allow), .serial_out_in(serial_out_in), .serial_out(serial_out));
  umc_remote_modem u_modem (.cts_n(cts_n), .dsr_n(dsr_n), .dcd_n(dcd_n), .ri_n(ri_n));
  // system clock on the crystal input, 50 MHz
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////
  task cyc(input int k);
    repeat (k) @(posedge ref_clk);
  endtask
  task wr(input [2:0] a, input [7:0] dv);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= dv;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input [2:0] a, input [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask
  task cmp(input logic g, input logic e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t: pin %b expected %b", $time, g, e);
    end
  endtask
  task cmpb(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t: byte %h expected %h", $time, g, e);
    end
  endtask
  task pins(input logic r, input logic t, input logic o);
    cmp(rts_n, r);
    cmp(dtr_n, t);
    cmp(mf, o);
  endtask
  task final_report;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // read data stands only in the cycle after the strobe; oldest note first
  always @(posedge ref_clk) begin
    if (rd_d === 1'b1) cmpb(reg_rdata, exp_q.pop_front());
    rd_d <= reg_rd;
  end
  // hang guard, well beyond the several hundred cycles the tests need
  initial begin
    #400000;
    mismatches++;
    final_report;
  end
  ////////////////////////////////////////
  initial begin
    {rst_n, master_reset, reg_wr, reg_rd, rx_data_ready, tx_request, rd_d} = 7'h00;
    {serial_out_in, reg_addr, reg_wdata, lvl, trig, p} = {1'b1, 3'h0, 8'h00, 7'h00, 7'h08, 4'hF};
    {mismatches, n_compared} = 0;
    n = $urandom(32'h19513E27);
    cyc(10);
    rst_n <= 1'b1;
    cyc(2);
    #1;
    pins(1'b1, 1'b1, 1'b1);
    wr(`UMC_ADDR_IER, 8'h08);
    for (i = 0; i < 8; i++) begin
      v = $urandom & 8'h0B;
      wr(`UMC_ADDR_MCR, v);
      cyc(2);
      #1;
      pins(!v[1], !v[0], !v[3]);
      rd(`UMC_ADDR_MCR, v);
    end
    // loop mode parks the pins; status follows control bits
    wr(`UMC_ADDR_MCR, 8'h1B);
    cyc(2);
    #1;
    pins(1'b1, 1'b1, 1'b1);
    wr(`UMC_ADDR_MCR, 8'h00);
    cyc(8);
    rd(`UMC_ADDR_MSR, 8'h0B);
    // each pin goes active then back; ring flags only its release
    for (i = 0; i < 8; i++) begin
      prev = p;
      p[i % 4] = ~p[i % 4];
      u_modem.drive(p);
      cyc(8);
      f = p ^ prev;
      f[2] = f[2] & p[2];
      #1;
      cmp(intr, |f);
      rd(`UMC_ADDR_MSR, {~p, f});
      rd(`UMC_ADDR_MSR, {~p, 4'h0});
      cyc(2);
      #1;
      cmp(intr, 1'b0);
    end
    rd(3'h7, 8'h00);
    // divisor and baud clock on the multi-function pin
    d = 8'h02 + ($urandom & 8'h07);
    wr(`UMC_ADDR_LCR, 8'h80);
    wr(`UMC_ADDR_DLL, d);
    wr(`UMC_ADDR_DLM, 8'h00);
    wr(`UMC_ADDR_AFR, 8'h02);
    rd(`UMC_ADDR_DLL, d);
    {n, m} = 0;
    // start from the level sampled at the last edge so only rises inside the window count
    last = mf;
    repeat (40 * d) begin
      @(posedge ref_clk);
      n += rx_sample_en;
      if (mf === 1'b1 && last === 1'b0) m++;
      last = mf;
    end
    cmpb(n[7:0], 8'h28);
    cmpb(m[7:0], 8'h28);
    wr(`UMC_ADDR_AFR, 8'h04);
    for (i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      rx_data_ready <= $urandom;
      cyc(3);
      #1;
      cmp(mf, !rx_data_ready);
    end
    // automatic flow: fill level against trigger, cts gates transmit
    wr(`UMC_ADDR_MCR, 8'h22);
    for (i = 0; i < 6; i++) begin
      @(posedge ref_clk);
      lvl <= 7'h05 + i;
      tx_request <= $urandom;
      cyc(2);
      p[0] = i[0];
      u_modem.drive(p);
      cyc(5);
      #1;
      cmp(rts_n, lvl >= trig);
      cmp(tx_allow, tx_request & !p[0]);
    end
    wr(`UMC_ADDR_MCR, 8'h0B);
    @(posedge ref_clk);
    master_reset <= 1'b1;
    serial_out_in <= 1'b0;
    @(posedge ref_clk);
    master_reset <= 1'b0;
    reg_addr <= `UMC_ADDR_MCR;
    reg_rd <= 1'b1;
    exp_q.push_back(8'h00);
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    pins(1'b1, 1'b1, 1'b1);
    cmp(intr, 1'b0);
    cmp(serial_out, 1'b0);
    wr(`UMC_ADDR_LCR, 8'h80);
    rd(`UMC_ADDR_DLL, d);
    rd(`UMC_ADDR_AFR, 8'h00);
    cyc(4);
    final_report;
  end
endmodule

// File: bench/umc_remote_modem.sv
// umc_remote_modem.sv: remote modem driving the four status pins
// assumes: pins are asynchronous to the block clock; the bench calls drive
`timescale 1ns/10ps
module umc_remote_modem (
  output logic cts_n,
  output logic dsr_n,
  output logic dcd_n,
  output logic ri_n
);
  // idle modem: every status pin inactive high
  initial {dcd_n, ri_n, dsr_n, cts_n} = 4'hF;
  // pins move 7 ns after the call, away from the block clock edge
  task drive(input logic [3:0] v);
    #7;
    {dcd_n, ri_n, dsr_n, cts_n} = v;
  endtask
endmodule

// File: rtl/umc_modem_ctrl.v
// umc_modem_ctrl.v: modem handshake pins, modem status register and multi-function output of one channel
// assumes: one clock ref_clk standing in for the crystal input, modem pins asynchronous to it,
// receive fifo level and transmitter request supplied by the surrounding channel logic
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`include "umc_regs.vh"

module umc_modem_ctrl #(
  parameter DIV_W = 16,
  parameter LVL_W = 7
) (
  input wire ref_clk,
  input wire rst_n,
  input wire master_reset,
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire cts_n,
  input wire dsr_n,
  input wire dcd_n,
  input wire ri_n,
  output reg rts_n,
  output reg dtr_n,
  output reg multi_function_pin,
  output reg intr,
  output wire crystal_output,
  output wire rx_sample_en,
  input wire [LVL_W-1:0] rx_fifo_level,
  input wire [LVL_W-1:0] rx_trigger_level,
  input wire rx_data_ready,
  input wire tx_request,
  output wire tx_allow,
  input wire serial_out_in,
  output reg serial_out
);

  ////////////////////////////////////////////////////////////////////////////
  // registers written by software

  reg [7:0] int_enable;
  reg [7:0] modem_control_reg;
  reg [7:0] line_ctrl;
  reg [7:0] alt_func;
  reg [DIV_W-1:0] divisor;
  reg [7:0] modem_status_reg;
  wire loop_mode;
  wire auto_flow;
  wire dlab;

  assign loop_mode = modem_control_reg[`UMC_MCR_LOOP];
  assign auto_flow = modem_control_reg[`UMC_MCR_AFE];
  assign dlab = line_ctrl[`UMC_LCR_DLAB];

  // master reset clears control state; divisor is deliberately kept
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_enable <= `UMC_RST_BYTE;
      modem_control_reg <= `UMC_RST_BYTE;
      line_ctrl <= `UMC_RST_BYTE;
      alt_func <= `UMC_RST_BYTE; // user_output_two selected at power-up
    end else if (master_reset) begin
      int_enable <= `UMC_RST_BYTE;
      modem_control_reg <= `UMC_RST_BYTE;
      line_ctrl <= `UMC_RST_BYTE;
      alt_func <= `UMC_RST_BYTE;
    end else if (reg_wr) begin
      case (reg_addr)
        `UMC_ADDR_IER: begin
          if (!dlab) begin
            int_enable <= reg_wdata;
          end
        end
        `UMC_ADDR_FCR: begin
          if (dlab) begin
            alt_func <= reg_wdata;
          end
        end
        `UMC_ADDR_LCR: begin
          line_ctrl <= reg_wdata;
        end
        `UMC_ADDR_MCR: begin
          modem_control_reg <= reg_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // divisor latches survive master reset; only the power-on reset sets them
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      divisor <= `UMC_RST_DIV;
    end else if (reg_wr && dlab && reg_addr == `UMC_ADDR_DLL) begin
      divisor[7:0] <= reg_wdata;
    end else if (reg_wr && dlab && reg_addr == `UMC_ADDR_DLM) begin
      divisor[DIV_W-1:8] <= reg_wdata[DIV_W-9:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // modem input synchronisers and status

  wire [3:0] pins_n;
  reg [3:0] sync1;
  reg [3:0] sync2;
  wire [3:0] pin_status;
  wire [3:0] loop_status;
  wire [3:0] live_status;
  reg [3:0] last_status;
  wire [3:0] change;
  wire msr_read;

  // order: cts, dsr, ri, dcd, matching status bits 4..7
  assign pins_n = {dcd_n, ri_n, dsr_n, cts_n};

  // two stages before anything looks at the pins
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= 4'hF;
      sync2 <= 4'hF;
    end else begin
      sync1 <= pins_n;
      sync2 <= sync1;
    end
  end

  // reported bits are the complement of the pins
  assign pin_status = ~sync2;
  // in loop mode the status follows the control bits instead of the pins
  assign loop_status = {modem_control_reg[`UMC_MCR_USER_OUTPUT_TWO], modem_control_reg[2],
                        modem_control_reg[`UMC_MCR_DTR], modem_control_reg[`UMC_MCR_RTS]};
  assign live_status = loop_mode ? loop_status : pin_status;
  assign msr_read = reg_rd && reg_addr == `UMC_ADDR_MSR;

  // per-bit change detection; ring reports only a trailing edge
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_chg
      if (gi == 2) begin : g_ring
        assign change[gi] = last_status[gi] & ~live_status[gi];
      end else begin : g_lvl
        assign change[gi] = last_status[gi] ^ live_status[gi];
      end
    end
  endgenerate

  // sticky change flags; a change in the read cycle wins over the clear
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      last_status <= 4'h0;
      modem_status_reg <= `UMC_RST_BYTE;
    end else begin
      last_status <= live_status;
      modem_status_reg[7:4] <= live_status;
      if (master_reset) begin
        modem_status_reg[3:0] <= 4'h0;
      end else if (msr_read) begin
        modem_status_reg[3:0] <= change;
      end else begin
        modem_status_reg[3:0] <= modem_status_reg[3:0] | change;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt: modem status is the only source kept here
  // dcd feeds status and interrupt only, no path reaches the receiver

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      intr <= 1'b0;
    end else if (master_reset) begin
      intr <= 1'b0;
    end else begin
      intr <= int_enable[`UMC_IER_MSI] & (|modem_status_reg[3:0]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // baud generator: 16x enable pulse, crystal divided by the divisor

  reg [DIV_W-1:0] baud_cnt;
  reg baud_clk;
  wire [DIV_W-1:0] half_div;

  assign half_div = {1'b0, divisor[DIV_W-1:1]};

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      baud_cnt <= {DIV_W{1'b0}};
      baud_clk <= 1'b0;
    end else if (baud_cnt + {{(DIV_W-1){1'b0}}, 1'b1} >= divisor) begin
      baud_cnt <= {DIV_W{1'b0}};
      baud_clk <= 1'b1;
    end else begin
      baud_cnt <= baud_cnt + {{(DIV_W-1){1'b0}}, 1'b1};
      baud_clk <= (baud_cnt + {{(DIV_W-1){1'b0}}, 1'b1}) < half_div;
    end
  end

  // same tick paces the receiver sampler; no separate receive clock exists
  assign rx_sample_en = (baud_cnt == {DIV_W{1'b0}});
  // crystal output is unused when the system feeds a clock on the crystal input
  assign crystal_output = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // handshake outputs

  wire rx_below_trigger;
  wire user_output_two_n;
  wire [1:0] mf_sel;

  assign rx_below_trigger = rx_fifo_level < rx_trigger_level;
  // with automatic flow on, transmitter may only send while partner holds cts active
  assign tx_allow = tx_request & (~auto_flow | pin_status[0]);
  assign user_output_two_n = ~modem_control_reg[`UMC_MCR_USER_OUTPUT_TWO] | loop_mode;
  assign mf_sel = alt_func[`UMC_AFR_SEL_HI:`UMC_AFR_SEL_LO];

  // master reset parks everything inactive; loop mode parks rts, dtr and serial out
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rts_n <= 1'b1;
      dtr_n <= 1'b1;
      serial_out <= 1'b1;
      multi_function_pin <= 1'b1;
    end else if (master_reset) begin
      rts_n <= 1'b1;
      dtr_n <= 1'b1;
      serial_out <= 1'b1;
      multi_function_pin <= 1'b1;
    end else begin
      if (loop_mode) begin
        rts_n <= 1'b1;
        dtr_n <= 1'b1;
        serial_out <= 1'b1;
      end else begin
        dtr_n <= ~modem_control_reg[`UMC_MCR_DTR];
        serial_out <= serial_out_in;
        if (auto_flow) begin
          rts_n <= ~(modem_control_reg[`UMC_MCR_RTS] & rx_below_trigger);
        end else begin
          rts_n <= ~modem_control_reg[`UMC_MCR_RTS];
        end
      end
      // exactly one source on the shared pin
      case (mf_sel)
        `UMC_MF_USER_OUTPUT_TWO: multi_function_pin <= user_output_two_n;
        `UMC_MF_BAUD: multi_function_pin <= baud_clk;
        `UMC_MF_RECEIVE_DMA_REQUEST: multi_function_pin <= ~rx_data_ready;
        default: multi_function_pin <= user_output_two_n;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path: data one cycle after the strobe

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `UMC_ADDR_IER: reg_rdata <= dlab ? divisor[DIV_W-1:8] : int_enable;
        `UMC_ADDR_FCR: reg_rdata <= dlab ? alt_func : {7'h00, ~intr};
        `UMC_ADDR_LCR: reg_rdata <= line_ctrl;
        `UMC_ADDR_MCR: reg_rdata <= modem_control_reg;
        `UMC_ADDR_MSR: reg_rdata <= modem_status_reg;
        `UMC_ADDR_STAT: reg_rdata <= {6'h00, tx_allow, rx_below_trigger};
        `UMC_ADDR_DLL: reg_rdata <= dlab ? divisor[7:0] : 8'h00;
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule

// File: rtl/umc_regs.vh
// umc_regs.vh: register offsets, field positions and reset values of the modem control block
// assumes: included by the design file and the self-checking bench of the modem control block
`ifndef UMC_REGS_VH
`define UMC_REGS_VH

// register offsets on the plain register port
`define UMC_ADDR_IER 3'h1
`define UMC_ADDR_FCR 3'h2
`define UMC_ADDR_MCR 3'h4
`define UMC_ADDR_MSR 3'h6
`define UMC_ADDR_DLL 3'h0
`define UMC_ADDR_DLM 3'h1
`define UMC_ADDR_AFR 3'h2
`define UMC_ADDR_LCR 3'h3
`define UMC_ADDR_STAT 3'h5

// modem control fields
`define UMC_MCR_DTR 0
`define UMC_MCR_RTS 1
`define UMC_MCR_USER_OUTPUT_TWO 3
`define UMC_MCR_LOOP 4
`define UMC_MCR_AFE 5

// modem status fields
`define UMC_MSR_DCTS 0
`define UMC_MSR_DDSR 1
`define UMC_MSR_TERI 2
`define UMC_MSR_DDCD 3
`define UMC_MSR_CTS 4
`define UMC_MSR_DSR 5
`define UMC_MSR_RI 6
`define UMC_MSR_DCD 7

// interrupt enable, line control, alternate function fields
`define UMC_IER_MSI 3
`define UMC_LCR_DLAB 7
`define UMC_AFR_SEL_LO 1
`define UMC_AFR_SEL_HI 2

// multi-function pin selections
`define UMC_MF_USER_OUTPUT_TWO 2'h0
`define UMC_MF_BAUD 2'h1
`define UMC_MF_RECEIVE_DMA_REQUEST 2'h2

// reset values
`define UMC_RST_BYTE 8'h00
`define UMC_RST_DIV 16'h0001

`endif
